/* File: strap_capture.sv */
/*
  strap_capture: samples boot straps while cold reset is low and holds the
  decoded configuration afterwards; AXI4-Lite slave for status and control.
  assumes: all inputs synchronous to clk; rst_n clears the block once at power up;
  cold_reset_n and pci_reset_n are pin levels driven by board logic.
*/
`timescale 1ns/1ps

// Overview of operation
// R1: straps are sampled during cold reset, settings held once it ends.
// R2: clock code 0,1,2 gives core clock times 2,3,4; 3..7 reserved.
// R3: mode bit 3 picks byte order, zero little-endian, one big-endian.
// R4: mode bit 6 zero enables timer interrupt five, one disables it.
// R5: board must strap bits 4,5 as zero and bit 7 as one.
// R6: width code 00/01/10 gives 8/16/32 bit boot memory; 11 reserved.
// R7: boot code 11 floats memory and eeprom buses while cold reset lasts.
// R8: board must not strap boot code 10.
// R9: boot code 01 boots over PCI, valid only in satellite role.
// R10: in PCI boot, both cold reset and PCI reset reset the device.
// R11: boot code 00 fetches initial code through the memory controller.
// R12: a non-PCI-boot cold reset may move register base to 1900_0000.
// R13: memory address bit 20 high selects satellite, low selects host.
// R14: in host role software programs every PCI configuration register.
// R15: satellite with PCI boot loads read-only PCI registers from eeprom.
// R16: outside reset, mode bits 3..6 pins become debug outputs.
module strap_capture
  import strap_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  input  wire logic                  cold_reset_n,
  input  wire logic                  pci_reset_n,
  input  wire logic [2:0]            pcst_in,
  input  wire debug_pin_type         dbg_pin_in,
  input  wire logic [5:0]            mem_addr_strap,
  input  wire debug_event_type       dbg_event,
  output debug_pin_type              dbg_pin_out,
  output debug_pin_type              dbg_pin_oe,
  output config_type                 cfg,
  output strap_error_type            strap_err,
  output logic                       mem_bus_float,
  output logic                       eeprom_bus_float,
  output logic                       core_reset_n,
  output logic                       cold_in_reset,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  output logic [1:0]                 s_axi_bresp,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  input  wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp
);

  // ************************************************************
  // functions
  // ************************************************************
  function automatic logic [2:0] clock_factor(input logic [2:0] code);
    clock_factor = (code <= CLK_CODE_MAX) ? 3'(code + CLK_FACTOR_BASE) : CLK_FACTOR_BASE;
  endfunction

  function automatic logic reg_mapped(input logic [AXI_ADDR_W-1:0] addr);
    reg_mapped = (addr == OFS_MODE_BITS) || (addr == OFS_CONFIG_STATUS) ||
                 (addr == OFS_CONTROL)   || (addr == OFS_REG_BASE);
  endfunction

  // both buses float together, so one decode feeds both
  function automatic logic floats_bus(input logic cold_n, input logic [1:0] boot);
    floats_bus = !cold_n && (boot == BOOT_FLOAT);
  endfunction

  // ************************************************************
  // strap assembly
  // ************************************************************
  logic [MODE_W-1:0] live_mode;
  logic [1:0]        live_boot;
  logic              live_sat;
  logic              live_pci_boot;
  logic [MODE_W-1:0] mode_raw;
  logic [1:0]        boot_raw;
  logic              relocate;

  assign live_mode = {mem_addr_strap[MA_WIDTH_LO+1:MA_WIDTH_LO], mem_addr_strap[MA_MODE7],
                      dbg_pin_in.dma_n, dbg_pin_in.ads_n, dbg_pin_in.ack_n,
                      dbg_pin_in.i_d_n, pcst_in};
  assign live_boot = mem_addr_strap[MA_BOOT_LO+1:MA_BOOT_LO];
  // R13 role strap
  assign live_sat  = mem_addr_strap[MA_ROLE];
  // R9 pci boot needs satellite
  assign live_pci_boot = (live_boot == BOOT_PCI) && live_sat;

  // ************************************************************
  // capture during cold reset
  // ************************************************************
  // R1 sample then hold
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cfg      <= CFG_RESET;
      mode_raw <= '0;
      boot_raw <= BOOT_STANDARD;
    end else if (!cold_reset_n) begin
      mode_raw <= live_mode;
      boot_raw <= live_boot;
      // R2 clock multiplier
      cfg.core_pipeline_clock_mult <= clock_factor(live_mode[2:0]);
      // R3 byte order
      cfg.byte_order_select        <= live_mode[3];
      // R4 timer interrupt gate
      cfg.timer_irq_gate           <= ~live_mode[6];
      // R6 boot width
      cfg.boot_width_code          <= live_mode[9:8];
      cfg.pci_boot                 <= live_pci_boot;
      // R11 standard boot path
      cfg.standard_boot            <= ~live_pci_boot;
      cfg.pci_satellite            <= live_sat;
      // R15 eeprom config load
      cfg.pci_cfg_from_eeprom      <= live_pci_boot;
      // R14 host programs config
      cfg.cpu_programs_pci_cfg     <= ~live_sat;
      // R12 register base move
      cfg.reg_base                 <= (relocate && !live_pci_boot) ? REG_BASE_ALT : REG_BASE_DEFAULT;
    end
  end

  // reserved clock codes fall back to factor 2, a reserved width code is kept as strapped; the flags let software see it
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      strap_err <= '0;
    end else if (!cold_reset_n) begin
      // R2 reserved clock codes
      strap_err.clk_code_reserved     <= live_mode[2:0] > CLK_CODE_MAX;
      // R5 reserved mode bits
      strap_err.reserved_bits_bad     <= {live_mode[7], live_mode[5], live_mode[4]} != RSVD_MODE_EXPECT;
      // R6 reserved width
      strap_err.width_reserved        <= live_mode[9:8] == WIDTH_RESERVED;
      // R8 reserved boot code
      strap_err.boot_reserved         <= live_boot == BOOT_RESERVED;
      // R9 pci boot in host role
      strap_err.pci_boot_no_satellite <= (live_boot == BOOT_PCI) && !live_sat;
    end
  end

  // ************************************************************
  // reset outputs
  // ************************************************************
  // R7 float buses in reset
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mem_bus_float    <= 1'b0;
      eeprom_bus_float <= 1'b0;
    end else begin
      mem_bus_float    <= floats_bus(cold_reset_n, live_boot);
      eeprom_bus_float <= floats_bus(cold_reset_n, live_boot);
    end
  end

  // R10 pci reset source
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      core_reset_n  <= 1'b0;
      cold_in_reset <= 1'b1;
    end else begin
      core_reset_n  <= cold_reset_n && !(cfg.pci_boot && !pci_reset_n);
      cold_in_reset <= !cold_reset_n;
    end
  end

  debug_pin_driver u_debug_pins (
    .clk           (clk),
    .rst_n         (rst_n),
    .cold_in_reset (cold_in_reset),
    .dbg_event     (dbg_event),
    .pin_out       (dbg_pin_out),
    .pin_oe        (dbg_pin_oe)
  );

  // ************************************************************
  // axi4-lite write channel
  // ************************************************************
  logic                  aw_got;
  logic                  w_got;
  logic [AXI_ADDR_W-1:0] aw_addr;
  logic [31:0]           w_data;
  logic [3:0]            w_strb;

  // address and data may arrive in either order; response one cycle after both
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      aw_got        <= 1'b0;
      w_got         <= 1'b0;
      aw_addr       <= '0;
      w_data        <= '0;
      w_strb        <= '0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got        <= 1'b1;
        aw_addr       <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got        <= 1'b1;
        w_data       <= s_axi_wdata;
        w_strb       <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
      if (aw_got && w_got && !s_axi_bvalid) begin
        aw_got <= 1'b0;
        w_got  <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (aw_got && w_got && !s_axi_bvalid) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= reg_mapped(aw_addr) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // control survives cold reset so software can arm a move for the next one
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      relocate <= CTRL_RELOCATE_RST;
    end else if (aw_got && w_got && !s_axi_bvalid && aw_addr == OFS_CONTROL && w_strb[0]) begin
      relocate <= w_data[CTRL_RELOCATE_POS];
    end
  end

  // ************************************************************
  // axi4-lite read channel
  // ************************************************************
  logic [31:0] read_word;

  always_comb begin
    read_word = '0;
    unique case (s_axi_araddr)
      OFS_MODE_BITS:     read_word = {20'h0, boot_raw, mode_raw};
      OFS_CONFIG_STATUS: read_word = {14'h0, cold_in_reset, strap_err, cfg.cpu_programs_pci_cfg,
                                      cfg.pci_cfg_from_eeprom, cfg.pci_satellite, cfg.standard_boot,
                                      cfg.pci_boot, cfg.boot_width_code, cfg.timer_irq_gate,
                                      cfg.byte_order_select, cfg.core_pipeline_clock_mult};
      OFS_CONTROL:       read_word = {31'h0, relocate};
      OFS_REG_BASE:      read_word = cfg.reg_base;
      default:           read_word = '0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= read_word;
      s_axi_rresp   <= reg_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  a_cfg_held: assert property (@(posedge clk) disable iff (!rst_n) // R1
    cold_reset_n && $past(rst_n) |=> $stable(cfg)) else $error("configuration changed outside cold reset");
  a_clock_factor: assert property (@(posedge clk) disable iff (!rst_n) // R2
    !cold_reset_n && pcst_in == 3'h1 |=> cfg.core_pipeline_clock_mult == 3'h3)
    else $error("clock code 1 did not give factor 3");
  a_byte_order: assert property (@(posedge clk) disable iff (!rst_n) // R3
    !cold_reset_n |=> cfg.byte_order_select == $past(dbg_pin_in.i_d_n)) else $error("byte order not captured");
  a_timer_gate: assert property (@(posedge clk) disable iff (!rst_n) // R4
    !cold_reset_n |=> cfg.timer_irq_gate != $past(dbg_pin_in.dma_n)) else $error("timer gate polarity wrong");
  a_boot_width: assert property (@(posedge clk) disable iff (!rst_n) // R6
    !cold_reset_n |=> cfg.boot_width_code == $past(mem_addr_strap[MA_WIDTH_LO+1:MA_WIDTH_LO]))
    else $error("boot width not captured");
  a_float_cause: assert property (@(posedge clk) disable iff (!rst_n) // R7
    mem_bus_float |-> !$past(cold_reset_n) && $past(live_boot) == BOOT_FLOAT && eeprom_bus_float)
    else $error("bus floated without cause");
  a_float_ends: assert property (@(posedge clk) disable iff (!rst_n) // R7
    cold_reset_n ##1 cold_reset_n |-> !mem_bus_float && !eeprom_bus_float) else $error("bus still floated");
  a_pci_boot_role: assert property (@(posedge clk) disable iff (!rst_n) // R9
    cfg.pci_boot |-> cfg.pci_satellite && cfg.pci_cfg_from_eeprom && !cfg.standard_boot)
    else $error("pci boot without satellite role");
  a_pci_reset: assert property (@(posedge clk) disable iff (!rst_n) // R10
    cold_reset_n && cfg.pci_boot && !pci_reset_n |=> !core_reset_n) else $error("pci reset ignored");
  a_base_move: assert property (@(posedge clk) disable iff (!rst_n) // R12
    cfg.reg_base == REG_BASE_ALT |-> !cfg.pci_boot) else $error("base moved in pci boot");
  a_clock_reserved: assert property (@(posedge clk) disable iff (!rst_n) // R2
    !cold_reset_n && pcst_in > CLK_CODE_MAX |=> strap_err.clk_code_reserved
      && cfg.core_pipeline_clock_mult == CLK_FACTOR_BASE) else $error("reserved clock code not flagged");
  a_std_boot: assert property (@(posedge clk) disable iff (!rst_n) // R11
    !cold_reset_n && mem_addr_strap[MA_BOOT_LO+1:MA_BOOT_LO] == BOOT_STANDARD
      |=> cfg.standard_boot && !cfg.pci_boot) else $error("standard boot not selected");
  a_role_capture: assert property (@(posedge clk) disable iff (!rst_n) // R13
    !cold_reset_n |=> cfg.pci_satellite == $past(mem_addr_strap[MA_ROLE])
      && cfg.cpu_programs_pci_cfg != cfg.pci_satellite) else $error("pci role not captured");
  a_eeprom_load: assert property (@(posedge clk) disable iff (!rst_n) // R15
    !cold_reset_n && mem_addr_strap[MA_ROLE] && mem_addr_strap[MA_BOOT_LO+1:MA_BOOT_LO] == BOOT_PCI
      |=> cfg.pci_cfg_from_eeprom) else $error("eeprom load not selected");
  a_cold_flag: assert property (@(posedge clk) disable iff (!rst_n) // R1
    $past(rst_n) |-> cold_in_reset == !$past(cold_reset_n)) else $error("cold reset flag wrong");
  a_bresp_hold: assert property (@(posedge clk) disable iff (!rst_n)
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  a_rresp_hold: assert property (@(posedge clk) disable iff (!rst_n)
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");

  c_pci_boot: cover property (@(posedge clk) disable iff (!rst_n) !cold_reset_n ##1 cold_reset_n && cfg.pci_boot);
  c_relocated: cover property (@(posedge clk) disable iff (!rst_n) cfg.reg_base == REG_BASE_ALT);
  c_float: cover property (@(posedge clk) disable iff (!rst_n) mem_bus_float ##1 !mem_bus_float);
  c_write: cover property (@(posedge clk) disable iff (!rst_n) s_axi_bvalid && s_axi_bready);
  c_pci_reset: cover property (@(posedge clk) disable iff (!rst_n) cfg.pci_boot && cold_reset_n && !core_reset_n);

endmodule // strap_capture

/* File: strap_pkg.sv */
/*
  strap_pkg: constants, field layouts and carrier types for the cold reset
  mode strap capture block and its debug pin driver.
  assumes: compiled before every file that imports it.
*/
package strap_pkg;

  // ************************************************************
  // register bus map
  // ************************************************************
  localparam int          AXI_ADDR_W        = 8;
  localparam logic [7:0]  OFS_MODE_BITS     = 8'h00;
  localparam logic [7:0]  OFS_CONFIG_STATUS = 8'h04;
  localparam logic [7:0]  OFS_CONTROL       = 8'h08;
  localparam logic [7:0]  OFS_REG_BASE      = 8'h0C;
  localparam logic [1:0]  RESP_OKAY         = 2'h0;
  localparam logic [1:0]  RESP_SLVERR       = 2'h2;
  localparam int          CTRL_RELOCATE_POS = 0;
  localparam logic        CTRL_RELOCATE_RST = 1'b0;

  // ************************************************************
  // strap positions and codes
  // ************************************************************
  localparam int          MODE_W            = 10;
  localparam int          MA_LSB            = 17;   // mem_addr_strap bit 0 is mem_addr[17]
  localparam int          MA_MODE7          = 17 - MA_LSB;
  localparam int          MA_WIDTH_LO       = 18 - MA_LSB;
  localparam int          MA_ROLE           = 20 - MA_LSB;
  localparam int          MA_BOOT_LO        = 21 - MA_LSB;
  localparam logic [2:0]  CLK_CODE_MAX      = 3'h2;
  localparam logic [2:0]  CLK_FACTOR_BASE   = 3'h2;
  localparam logic [1:0]  WIDTH_RESERVED    = 2'h3;
  localparam logic [1:0]  BOOT_STANDARD     = 2'h0;
  localparam logic [1:0]  BOOT_PCI          = 2'h1;
  localparam logic [1:0]  BOOT_RESERVED     = 2'h2;
  localparam logic [1:0]  BOOT_FLOAT        = 2'h3;
  localparam logic [2:0]  RSVD_MODE_EXPECT  = 3'h4;   // bits 7,5,4 = 1,0,0
  localparam logic [31:0] REG_BASE_DEFAULT  = 32'h1800_0000;
  localparam logic [31:0] REG_BASE_ALT      = 32'h1900_0000;

  // ************************************************************
  // carrier types
  // ************************************************************
  typedef struct packed {
    logic [2:0]  core_pipeline_clock_mult;
    logic        byte_order_select;
    logic        timer_irq_gate;
    logic [1:0]  boot_width_code;
    logic        pci_boot;
    logic        standard_boot;
    logic        pci_satellite;
    logic        pci_cfg_from_eeprom;
    logic        cpu_programs_pci_cfg;
    logic [31:0] reg_base;
  } config_type;

  typedef struct packed {
    logic clk_code_reserved;
    logic reserved_bits_bad;
    logic width_reserved;
    logic boot_reserved;
    logic pci_boot_no_satellite;
  } strap_error_type;

  typedef struct packed {
    logic bus_start;
    logic bus_ack;
    logic is_instruction;
    logic from_dma;
  } debug_event_type;

  typedef struct packed {
    logic dma_n;
    logic ads_n;
    logic ack_n;
    logic i_d_n;
  } debug_pin_type;

  localparam config_type CFG_RESET = '{
    core_pipeline_clock_mult: CLK_FACTOR_BASE,
    byte_order_select:        1'b0,
    timer_irq_gate:           1'b1,
    boot_width_code:          2'h0,
    pci_boot:                 1'b0,
    standard_boot:            1'b1,
    pci_satellite:            1'b0,
    pci_cfg_from_eeprom:      1'b0,
    cpu_programs_pci_cfg:     1'b1,
    reg_base:                 REG_BASE_DEFAULT
  };
  localparam debug_pin_type PINS_IDLE = 4'hF;

endpackage

/* File: debug_pin_driver.sv */
/*
  debug_pin_driver: drives the four shared debug pins once cold reset is over.
  assumes: cold_in_reset is a registered level; the pad resolves out and oe.
*/
`timescale 1ns/1ps
module debug_pin_driver
  import strap_pkg::*;
(
  input  wire logic            clk,
  input  wire logic            rst_n,
  input  wire logic            cold_in_reset,
  input  wire debug_event_type dbg_event,
  output debug_pin_type        pin_out,
  output debug_pin_type        pin_oe
);

  // ************************************************************
  // pin drive
  // ************************************************************
  // R16 debug outputs after reset
  always_ff @(posedge clk) begin
    if (!rst_n || cold_in_reset) begin
      pin_out <= PINS_IDLE;
      pin_oe  <= '0;
    end else begin
      pin_out.ads_n <= ~dbg_event.bus_start;
      pin_out.ack_n <= ~dbg_event.bus_ack;
      pin_out.i_d_n <= dbg_event.is_instruction;
      pin_out.dma_n <= ~dbg_event.from_dma;
      pin_oe        <= '1;
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  a_pins_released: assert property (@(posedge clk) disable iff (!rst_n)
    cold_in_reset |=> pin_oe == '0) else $error("debug pins driven during cold reset"); // R16
  a_pins_follow: assert property (@(posedge clk) disable iff (!rst_n)
    !cold_in_reset |=> pin_oe == '1 && pin_out.ads_n == !$past(dbg_event.bus_start)
      && pin_out.dma_n == !$past(dbg_event.from_dma)) else $error("debug pins do not follow events"); // R16

endmodule // debug_pin_driver

/* File: strap_board.sv */
/*
  strap_board: board model driving the mode strap pins.
  assumes: testbench picks strap values; device drives debug pins by oe.
*/
`timescale 1ns/1ps
module strap_board
  import strap_pkg::*;
(
  input  wire logic          cold_reset_n,
  input  wire logic [2:0]    pcst_val,
  input  wire logic [3:0]    dbg_val,
  input  wire logic [5:0]    ma_val,
  input  wire debug_pin_type dbg_pin_out,
  input  wire debug_pin_type dbg_pin_oe,
  output logic [2:0]         pcst_in,
  output debug_pin_type      dbg_pin_in,
  output logic [5:0]         mem_addr_strap
);
  // straps only in reset
  // released pins show the inverse so a late sample cannot match by luck
  assign pcst_in = cold_reset_n ? ~pcst_val : pcst_val;
  assign mem_addr_strap = cold_reset_n ? ~ma_val : ma_val;
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      dbg_pin_in[i] = dbg_pin_oe[i] ? dbg_pin_out[i] : (cold_reset_n ? ~dbg_val[i] : dbg_val[i]);
    end
  end
endmodule // strap_board

/* File: testbench.sv */
/*
  testbench: strap capture checks over cold reset, pci reset and AXI4-Lite.
  assumes: strap_board models the board; 40 MHz clock.
*/
`timescale 1ns/1ps
module testbench;
  import strap_pkg::*;
  logic clk, rst_n, cold_reset_n, pci_reset_n;
  logic [2:0] pcst_in, pcst_val;
  logic [3:0] dbg_val, s_axi_wstrb;
  logic [5:0] mem_addr_strap, ma_val;
  debug_pin_type dbg_pin_in, dbg_pin_out, dbg_pin_oe;
  debug_event_type dbg_event;
  config_type cfg, e_cfg;
  strap_error_type strap_err, e_err;
  logic mem_bus_float, eeprom_bus_float, core_reset_n, cold_in_reset;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [AXI_ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [13:0] rows [6];
  int err_count, n_checks, cycles;

  strap_capture DUT (.clk(clk), .rst_n(rst_n), .cold_reset_n(cold_reset_n), .pci_reset_n(pci_reset_n),
    .pcst_in(pcst_in), .dbg_pin_in(dbg_pin_in), .mem_addr_strap(mem_addr_strap), .dbg_event(dbg_event),
    .dbg_pin_out(dbg_pin_out), .dbg_pin_oe(dbg_pin_oe), .cfg(cfg), .strap_err(strap_err),
    .mem_bus_float(mem_bus_float), .eeprom_bus_float(eeprom_bus_float), .core_reset_n(core_reset_n),
    .cold_in_reset(cold_in_reset), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp));
  strap_board board (.cold_reset_n(cold_reset_n), .pcst_val(pcst_val), .dbg_val(dbg_val), .ma_val(ma_val),
    .dbg_pin_out(dbg_pin_out), .dbg_pin_oe(dbg_pin_oe), .pcst_in(pcst_in), .dbg_pin_in(dbg_pin_in),
    .mem_addr_strap(mem_addr_strap));

  // ************************************************************
  // tasks
  // ************************************************************
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      err_count++;
      print_verdict();
    end
  end
  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!(s_axi_bvalid && s_axi_bready));
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!(s_axi_rvalid && s_axi_rready));
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic cold(input logic [2:0] pc, input logic [3:0] m, input logic [5:0] ma, input logic rel);
    logic pb;
    pb = ma[5:4] == 2'h1 && ma[3];
    axi_wr(OFS_CONTROL, {31'h0, rel}, rsp);
    pcst_val <= pc;
    dbg_val <= m;
    ma_val <= ma;
    cold_reset_n <= 1'b0;
    repeat (3) @(posedge clk);
    chk("float in reset", {mem_bus_float, eeprom_bus_float}, {2{ma[5:4] == 2'h3}});
    chk("core reset held", core_reset_n, 1'b0);
    chk("pins released", dbg_pin_oe, 4'h0);
    chk("cold flag", cold_in_reset, 1'b1);
    cold_reset_n <= 1'b1;
    repeat (4) @(posedge clk);
    e_cfg = '{(pc <= 3'h2) ? pc + 3'h2 : 3'h2, m[0], !m[3], ma[2:1], pb, !pb, ma[3], pb, !ma[3],
      (rel && !pb) ? 32'h1900_0000 : 32'h1800_0000};
    e_err = '{pc > 3'h2, {ma[0], m[2:1]} != 3'h4, ma[2:1] == 2'h3, ma[5:4] == 2'h2, ma[5:4] == 2'h1 && !ma[3]};
    chk("cfg", 64'(cfg), 64'(e_cfg));
    chk("strap errors", 64'(strap_err), 64'(e_err));
    chk("float after", {mem_bus_float, eeprom_bus_float, core_reset_n}, 3'h1);
    chk("pins driven", dbg_pin_oe, 4'hF);
    axi_rd(OFS_CONFIG_STATUS, rd, rsp);
    chk("status", rd, {15'h0, e_err, e_cfg.cpu_programs_pci_cfg, e_cfg.pci_cfg_from_eeprom, e_cfg.pci_satellite,
      e_cfg.standard_boot, e_cfg.pci_boot, e_cfg.boot_width_code, e_cfg.timer_irq_gate,
      e_cfg.byte_order_select, e_cfg.core_pipeline_clock_mult});
    axi_rd(OFS_REG_BASE, rd, rsp);
    chk("reg base", rd, e_cfg.reg_base);
    axi_rd(OFS_MODE_BITS, rd, rsp);
    chk("mode bits", {rsp, rd}, {RESP_OKAY, 20'h0, ma[5:4], ma[2:1], ma[0], m, pc});
    pci_reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    chk("pci reset", core_reset_n, !pb);
    pci_reset_n <= 1'b1;
    @(posedge clk);
  endtask

  // ************************************************************
  // sequence
  // ************************************************************
  initial begin
    {rst_n, pci_reset_n, cold_reset_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 6'h18;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {pcst_val, dbg_val, ma_val, dbg_event} = '0;
    s_axi_wstrb = 4'hF;
    // rows of pc, mode 6..3, mem_addr straps, relocate
    rows = '{{3'h0, 4'h0, 6'h01, 1'h0}, {3'h1, 4'h9, 6'h1B, 1'h1}, {3'h2, 4'h0, 6'h05, 1'h1},
      {3'h3, 4'h6, 6'h26, 1'h1}, {3'h4, 4'h0, 6'h11, 1'h0}, {3'h7, 4'h0, 6'h39, 1'h0}};
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk("cfg reset", 64'(cfg), 64'(CFG_RESET));
    axi_rd(OFS_CONTROL, rd, rsp);
    chk("control reset", {rsp, rd}, {RESP_OKAY, 32'h0000_0000});
    axi_wr(OFS_REG_BASE, 32'h1234_5678, rsp);
    chk("ro write", rsp, RESP_OKAY);
    axi_rd(OFS_REG_BASE, rd, rsp);
    chk("base read only", rd, 32'h1800_0000);
    axi_rd(8'h10, rd, rsp);
    chk("unmapped", rsp, RESP_SLVERR);
    axi_wr(8'h10, 32'h0000_0001, rsp);
    chk("unmapped write", rsp, RESP_SLVERR);
    foreach (rows[i]) cold(rows[i][13:11], rows[i][10:7], rows[i][6:1], rows[i][0]);
    dbg_event <= 4'hA;
    repeat (2) @(posedge clk);
    chk("debug pins a", dbg_pin_out, 4'hB);
    dbg_event <= 4'h5;
    repeat (2) @(posedge clk);
    chk("debug pins b", dbg_pin_out, 4'h4);
    print_verdict();
  end
endmodule // testbench
